// file: hdl/efc_pkg.sv
// constants for the e1 error counter and alarm latch block
package efc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PRBS_ERR = 8'h10;
   localparam logic [7:0] IDX_PRBS_MF = 8'h11;
   localparam logic [7:0] IDX_ALARM = 8'h12;
   localparam logic [7:0] IDX_FAS = 8'h13;
   localparam logic [7:0] IDX_EBIT_HI = 8'h14;
   localparam logic [7:0] IDX_EBIT_LO = 8'h15;
   localparam logic [7:0] IDX_LV_HI = 8'h16;
   localparam logic [7:0] IDX_LV_LO = 8'h17;
   localparam logic [7:0] IDX_CRC_HI = 8'h18;
   localparam logic [7:0] IDX_CRC_LO = 8'h19;
   localparam logic [7:0] IDX_CTRL = 8'h20;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h21;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
   localparam int ADDR_LSB = 2;
   localparam int AW = 10;
   // control register fields
   localparam int CTRL_E1_BIT = 0;
   localparam int CTRL_PAGE_LSB = 4;
   localparam int PAGE_W = 3;
   localparam logic [PAGE_W-1:0] COUNTER_PAGE = 3'h4;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_MASK = 8'h71;
   // alarm latch bit positions
   localparam int AL_REMOTE = 7;
   localparam int AL_ALL_ONES = 6;
   localparam int AL_SLOT16 = 5;
   localparam int AL_LOSS = 4;
   localparam int AL_ALT = 3;
   localparam int AL_MULTIFRAME_ALARM_LATCH = 2;
   localparam int AL_SLIP = 1;
   // overflow status bit positions
   localparam int OV_PRBS = 0;
   localparam int OV_PRBS_MF = 1;
   localparam int OV_FAS = 2;
   localparam int OV_EBIT = 3;
   localparam int OV_LV = 4;
   localparam int OV_CRC = 5;
   localparam int OV_W = 6;
   // counter widths
   localparam int W_BYTE = 8;
   localparam int W_TEN = 10;
   localparam int W_LV = 16;
   // line pattern thresholds in bit periods
   localparam int LOSS_ZEROS = 192;
   localparam int ALT_BITS = 512;
   localparam int RUN_W = 10;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: hdl/efc_counters.sv
// e1 performance counters, clear-on-read alarm latch and axi4-lite slave
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module efc_event_counter #(parameter int W = 8)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic inc,
   input wire logic clr,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   // state
   output logic [W-1:0] count,
   output logic wrap
);
   logic [W-1:0] count_reg;
   assign count = count_reg;
   // wrap from all ones is an ordinary increment
   assign wrap = inc && !clr && !load && (&count_reg);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_reg <= '0;
      else if (clr)
         count_reg <= '0;
      else if (load)
         count_reg <= load_val;
      else if (inc)
         count_reg <= count_reg + 1'b1;
   end
endmodule

module efc_counters
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // receive framer events, one-cycle pulses
   input wire logic prbs_error,
   input wire logic crc_multiframe,
   input wire logic remote_alarm,
   input wire logic all_ones_alarm,
   input wire logic slot16_all_ones,
   input wire logic multiframe_alarm,
   input wire logic receive_slip,
   input wire logic fas_error,
   input wire logic ebit_error,
   input wire logic line_violation,
   input wire logic crc4_error,
   // received bit stream
   input wire logic rx_bit,
   input wire logic rx_bit_valid,
   // interrupt
   output logic irq
);
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg, irq_reg, w_lane0_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0] aw_idx_reg, w_data_reg, ctrl_reg, alarm_reg, alarm_next, wr_idx, rd_idx, rd_byte;
   logic [efc_pkg::OV_W-1:0] ov_stat_reg, ov_mask_reg, ov_event;
   logic [efc_pkg::RUN_W-1:0] zero_run_reg, alt_run_reg;
   logic prev_bit_reg, loss_reg, alt_reg, loss_set, alt_set, rd_hit, wr_hit;
   logic e1_on, page_ok, do_write, rd_take, wr_prbs, rd_alarm;
   logic [efc_pkg::W_BYTE-1:0] prbs_cnt, mf_cnt, fas_cnt;
   logic [efc_pkg::W_TEN-1:0] ebit_cnt, crc_cnt;
   logic [efc_pkg::W_LV-1:0] lv_cnt;
   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign irq = irq_reg;
   assign e1_on = ctrl_reg[efc_pkg::CTRL_E1_BIT];
   assign page_ok = ctrl_reg[efc_pkg::CTRL_PAGE_LSB +: efc_pkg::PAGE_W]
                    == efc_pkg::COUNTER_PAGE;
   // write path: address and data are taken in either order
   assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_idx = aw_idx_reg;
   assign rd_idx = s_axi_araddr[efc_pkg::ADDR_LSB +: 8];
   assign rd_take = s_axi_arvalid && arready_reg;
   assign wr_prbs = do_write && w_lane0_reg && page_ok
                    && wr_idx == efc_pkg::IDX_PRBS_ERR;
   assign rd_alarm = rd_take && page_ok && rd_idx == efc_pkg::IDX_ALARM;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b1;
         aw_idx_reg <= 8'h00;
      end
      else if (awready_reg && s_axi_awvalid)
      begin
         awready_reg <= 1'b0;
         aw_idx_reg <= s_axi_awaddr[efc_pkg::ADDR_LSB +: 8];
      end
      else if (do_write)
         awready_reg <= 1'b1;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wready_reg <= 1'b1;
         w_data_reg <= 8'h00;
         w_lane0_reg <= 1'b0;
      end
      else if (wready_reg && s_axi_wvalid)
      begin
         wready_reg <= 1'b0;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane0_reg <= s_axi_wstrb[0];
      end
      else if (do_write)
         wready_reg <= 1'b1;
   end
   // own registers answer on any page, counter group only on its page
   assign wr_hit = (wr_idx >= efc_pkg::IDX_CTRL && wr_idx <= efc_pkg::IDX_IRQ_MASK)
                   || (page_ok && wr_idx >= efc_pkg::IDX_PRBS_ERR
                       && wr_idx <= efc_pkg::IDX_CRC_LO);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg <= efc_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg <= wr_hit ? efc_pkg::RESP_OKAY : efc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end
   // control: e1 mode and page select; undefined bits hold zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_reg <= efc_pkg::CTRL_RESET;
      else if (do_write && w_lane0_reg && wr_idx == efc_pkg::IDX_CTRL)
         ctrl_reg <= w_data_reg & efc_pkg::CTRL_MASK;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ov_mask_reg <= '0;
      else if (do_write && w_lane0_reg && wr_idx == efc_pkg::IDX_IRQ_MASK)
         ov_mask_reg <= w_data_reg[efc_pkg::OV_W-1:0];
   end
   // counters; read-only ones ignore writes
   efc_event_counter #(.W(efc_pkg::W_BYTE)) u_prbs
   (
      .aclk(aclk), .aresetn(aresetn), .inc(prbs_error && e1_on), .clr(1'b0),
      .load(wr_prbs), .load_val(w_data_reg), .count(prbs_cnt), .wrap(ov_event[efc_pkg::OV_PRBS])
   );
   efc_event_counter #(.W(efc_pkg::W_BYTE)) u_prbs_mf
   (
      .aclk(aclk), .aresetn(aresetn), .inc(crc_multiframe && e1_on), .clr(wr_prbs),
      .load(1'b0), .load_val('0), .count(mf_cnt), .wrap(ov_event[efc_pkg::OV_PRBS_MF])
   );
   efc_event_counter #(.W(efc_pkg::W_BYTE)) u_fas
   (
      .aclk(aclk), .aresetn(aresetn), .inc(fas_error && e1_on), .clr(1'b0),
      .load(1'b0), .load_val('0), .count(fas_cnt), .wrap(ov_event[efc_pkg::OV_FAS])
   );
   efc_event_counter #(.W(efc_pkg::W_TEN)) u_ebit
   (
      .aclk(aclk), .aresetn(aresetn), .inc(ebit_error && e1_on), .clr(1'b0),
      .load(1'b0), .load_val('0), .count(ebit_cnt), .wrap(ov_event[efc_pkg::OV_EBIT])
   );
   efc_event_counter #(.W(efc_pkg::W_LV)) u_lv
   (
      .aclk(aclk), .aresetn(aresetn), .inc(line_violation && e1_on), .clr(1'b0),
      .load(1'b0), .load_val('0), .count(lv_cnt), .wrap(ov_event[efc_pkg::OV_LV])
   );
   efc_event_counter #(.W(efc_pkg::W_TEN)) u_crc
   (
      .aclk(aclk), .aresetn(aresetn), .inc(crc4_error && e1_on), .clr(1'b0),
      .load(1'b0), .load_val('0), .count(crc_cnt), .wrap(ov_event[efc_pkg::OV_CRC])
   );
   // loss of signal: run of zero bit periods, saturating
   assign loss_set = rx_bit_valid && !rx_bit && !loss_reg
                     && zero_run_reg == efc_pkg::RUN_W'(efc_pkg::LOSS_ZEROS - 1);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         zero_run_reg <= '0;
         loss_reg <= 1'b0;
      end
      else if (rx_bit_valid)
      begin
         if (rx_bit)
         begin
            zero_run_reg <= '0;
            loss_reg <= 1'b0;
         end
         else if (!loss_reg)
         begin
            zero_run_reg <= zero_run_reg + 1'b1;
            loss_reg <= loss_set;
         end
      end
   end
   // alternating pattern: run of bits each differing from the last
   assign alt_set = rx_bit_valid && rx_bit != prev_bit_reg && !alt_reg
                    && alt_run_reg == efc_pkg::RUN_W'(efc_pkg::ALT_BITS - 1);
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         alt_run_reg <= '0;
         alt_reg <= 1'b0;
         prev_bit_reg <= 1'b0;
      end
      else if (rx_bit_valid)
      begin
         prev_bit_reg <= rx_bit;
         if (rx_bit == prev_bit_reg)
         begin
            alt_run_reg <= '0;
            alt_reg <= 1'b0;
         end
         else if (!alt_reg)
         begin
            alt_run_reg <= alt_run_reg + 1'b1;
            alt_reg <= alt_set;
         end
      end
   end
   // alarm latch: a set in the reading cycle survives the clear
   always_comb
   begin
      alarm_next = rd_alarm ? 8'h00 : alarm_reg;
      if (e1_on)
      begin
         alarm_next[efc_pkg::AL_REMOTE] = alarm_next[efc_pkg::AL_REMOTE] | remote_alarm;
         alarm_next[efc_pkg::AL_ALL_ONES] = alarm_next[efc_pkg::AL_ALL_ONES] | all_ones_alarm;
         alarm_next[efc_pkg::AL_SLOT16] = alarm_next[efc_pkg::AL_SLOT16] | slot16_all_ones;
         alarm_next[efc_pkg::AL_LOSS] = alarm_next[efc_pkg::AL_LOSS] | loss_set;
         alarm_next[efc_pkg::AL_ALT] = alarm_next[efc_pkg::AL_ALT] | alt_set;
         alarm_next[efc_pkg::AL_MULTIFRAME_ALARM_LATCH] = alarm_next[efc_pkg::AL_MULTIFRAME_ALARM_LATCH] | multiframe_alarm;
         alarm_next[efc_pkg::AL_SLIP] = alarm_next[efc_pkg::AL_SLIP] | receive_slip;
      end
      alarm_next[0] = 1'b0;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         alarm_reg <= 8'h00;
      else
         alarm_reg <= alarm_next;
   end
   // overflow status: write one to clear, new event wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ov_stat_reg <= '0;
      else if (do_write && w_lane0_reg && wr_idx == efc_pkg::IDX_IRQ_STAT)
         ov_stat_reg <= (ov_stat_reg & ~w_data_reg[efc_pkg::OV_W-1:0]) | ov_event;
      else
         ov_stat_reg <= ov_stat_reg | ov_event;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_reg <= 1'b0;
      else
         irq_reg <= |(ov_stat_reg & ov_mask_reg);
   end
   // read decode; counter bytes read live, no snapshot across the pair
   always_comb
   begin
      rd_byte = 8'h00;
      rd_hit = page_ok || rd_idx >= efc_pkg::IDX_CTRL;
      unique case (rd_idx)
         efc_pkg::IDX_PRBS_ERR: rd_byte = prbs_cnt;
         efc_pkg::IDX_PRBS_MF: rd_byte = mf_cnt;
         efc_pkg::IDX_ALARM: rd_byte = alarm_reg;
         efc_pkg::IDX_FAS: rd_byte = fas_cnt;
         efc_pkg::IDX_EBIT_HI: rd_byte = {6'h00, ebit_cnt[9:8]};
         efc_pkg::IDX_EBIT_LO: rd_byte = ebit_cnt[7:0];
         efc_pkg::IDX_LV_HI: rd_byte = lv_cnt[15:8];
         efc_pkg::IDX_LV_LO: rd_byte = lv_cnt[7:0];
         efc_pkg::IDX_CRC_HI: rd_byte = {6'h00, crc_cnt[9:8]};
         efc_pkg::IDX_CRC_LO: rd_byte = crc_cnt[7:0];
         efc_pkg::IDX_CTRL: rd_byte = ctrl_reg;
         efc_pkg::IDX_IRQ_STAT: rd_byte = 8'(ov_stat_reg);
         efc_pkg::IDX_IRQ_MASK: rd_byte = 8'(ov_mask_reg);
         default: rd_hit = 1'b0;
      endcase
      if (!rd_hit)
         rd_byte = 8'h00;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= efc_pkg::RESP_OKAY;
      end
      else if (rd_take)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h00_0000, rd_byte};
         rresp_reg <= rd_hit ? efc_pkg::RESP_OKAY : efc_pkg::RESP_SLVERR;
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_prbs_count_step: assert property (prbs_error && e1_on && !wr_prbs |=>
      prbs_cnt == $past(prbs_cnt) + 8'h01) else $error("prbs count did not step");
   a_mf_write_clear: assert property (wr_prbs |=> mf_cnt == 8'h00)
      else $error("multiframe count not cleared by write");
   a_remote_latch: assert property (remote_alarm && e1_on |=> alarm_reg[7])
      else $error("remote alarm not latched");
   a_slot16_latch: assert property (slot16_all_ones && e1_on |=> alarm_reg[5])
      else $error("slot 16 alarm not latched");
   a_latch_hold: assert property (alarm_reg[2] && !rd_alarm |=> alarm_reg[2])
      else $error("latch bit lost without read");
   a_read_clears: assert property (rd_alarm && !multiframe_alarm |=>
      !alarm_reg[2] && rdata_reg[2] == $past(alarm_reg[2])) else $error("read did not clear");
   a_bit0_zero: assert property (alarm_reg[0] == 1'b0) else $error("latch bit 0 set");
   a_lv_wrap: assert property (line_violation && e1_on && lv_cnt == 16'hFFFF |=>
      lv_cnt == 16'h0000 && ov_stat_reg[4]) else $error("violation wrap not reported");
   a_loss_after_run: assert property (loss_set |=> loss_reg && alarm_reg[4] == e1_on)
      else $error("loss of signal not declared");
   a_ebit_split: assert property (rd_take && page_ok && rd_idx == 8'h14 |=>
      rdata_reg[7:2] == 6'h00) else $error("e-bit high register upper bits set");
   a_off_mode: assert property (!e1_on && !wr_prbs |=> prbs_cnt == $past(prbs_cnt))
      else $error("counter moved outside e1 mode");
   a_read_answer: assert property (rd_take |=> rvalid_reg ##0 !arready_reg)
      else $error("read not answered next cycle");
   c_alarm_read: cover property (alarm_reg[7] ##1 rd_alarm);
   c_loss: cover property (loss_set);
   c_alt: cover property (alt_set);
   c_irq: cover property (irq_reg);
endmodule

`default_nettype wire

// file: testbench/efc_counters_tb.sv
// self-checking bench for the e1 error counters and alarm latch
`timescale 1ns/1ns
`default_nettype none

module efc_counters_tb;
   logic aclk;
   logic aresetn;
   logic [9:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [9:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic [10:0] ev;
   logic rx_bit;
   logic rx_bit_valid;
   logic irq;
   int miscompares;
   int checked;

   efc_counters i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .prbs_error(ev[0]), .crc_multiframe(ev[1]), .remote_alarm(ev[2]),
      .all_ones_alarm(ev[3]), .slot16_all_ones(ev[4]), .multiframe_alarm(ev[5]),
      .receive_slip(ev[6]), .fas_error(ev[7]), .ebit_error(ev[8]),
      .line_violation(ev[9]), .crc4_error(ev[10]),
      .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .irq(irq)
   );

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic wrap_up;
      begin
         if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   task automatic give_up;
      begin
         miscompares++;
         wrap_up();
      end
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      begin
         checked++;
         if (seen !== exp)
         begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask

   // ready is registered, so its value half a cycle early is what the edge samples
   task automatic wr_chk(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] exp);
      logic aw_hs;
      logic w_hs;
      logic b_hs;
      logic [1:0] resp;
      int n;
      begin
         b_hs = 1'b0;
         n = 0;
         @(posedge aclk);
         s_axi_awaddr <= {idx, 2'b00};
         s_axi_awvalid <= 1'b1;
         s_axi_wdata <= {24'h000000, d};
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (!b_hs)
         begin
            @(negedge aclk);
            aw_hs = s_axi_awvalid & s_axi_awready;
            w_hs = s_axi_wvalid & s_axi_wready;
            b_hs = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs)
               s_axi_awvalid <= 1'b0;
            if (w_hs)
               s_axi_wvalid <= 1'b0;
            n++;
            if (n > 64)
               give_up();
         end
         s_axi_bready <= 1'b0;
         check($sformatf("bresp %h", idx), {30'h0, resp}, {30'h0, exp});
      end
   endtask

   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp_d, input logic [1:0] exp_r);
      logic ar_hs;
      logic r_hs;
      logic [31:0] d;
      logic [1:0] resp;
      int n;
      begin
         r_hs = 1'b0;
         n = 0;
         @(posedge aclk);
         s_axi_araddr <= {idx, 2'b00};
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         while (!r_hs)
         begin
            @(negedge aclk);
            ar_hs = s_axi_arvalid & s_axi_arready;
            r_hs = s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs)
               s_axi_arvalid <= 1'b0;
            n++;
            if (n > 64)
               give_up();
         end
         s_axi_rready <= 1'b0;
         check($sformatf("rdata %h", idx), d, {24'h000000, exp_d});
         check($sformatf("rresp %h", idx), {30'h0, resp}, {30'h0, exp_r});
      end
   endtask

   // a held level counts once per cycle, so n cycles give n events
   task automatic hold_ev(input logic [10:0] m, input int n);
      begin
         @(posedge aclk);
         ev <= m;
         repeat (n) @(posedge aclk);
         ev <= 11'h000;
      end
   endtask

   task automatic send_bits(input int n, input logic first, input logic alt);
      begin
         @(posedge aclk);
         for (int i = 0; i < n; i++)
         begin
            rx_bit <= first ^ (alt & i[0]);
            rx_bit_valid <= 1'b1;
            @(posedge aclk);
         end
         rx_bit_valid <= 1'b0;
      end
   endtask

   task automatic t_reset;
      begin
         rd_chk(efc_pkg::IDX_CTRL, 8'h00, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_PRBS_ERR, 8'h00, efc_pkg::RESP_SLVERR);
         rd_chk(8'h30, 8'h00, efc_pkg::RESP_SLVERR);
         wr_chk(8'h30, 8'hFF, efc_pkg::RESP_SLVERR);
         wr_chk(efc_pkg::IDX_PRBS_ERR, 8'h55, efc_pkg::RESP_SLVERR);
         hold_ev(11'h7FF, 3);
         wr_chk(efc_pkg::IDX_CTRL, 8'h31, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_LV_LO, 8'h00, efc_pkg::RESP_SLVERR);
         wr_chk(efc_pkg::IDX_CTRL, 8'h41, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_PRBS_ERR, 8'h00, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_ALARM, 8'h00, efc_pkg::RESP_OKAY);
         check("irq", {31'h0, irq}, 32'h0);
      end
   endtask

   task automatic t_latch;
      int pos [7] = '{efc_pkg::AL_REMOTE, efc_pkg::AL_ALL_ONES, efc_pkg::AL_SLOT16,
                      efc_pkg::AL_MULTIFRAME_ALARM_LATCH, efc_pkg::AL_SLIP, efc_pkg::AL_SLIP, efc_pkg::AL_SLIP};
      begin
         pos[3] = efc_pkg::AL_MULTIFRAME_ALARM_LATCH;
         for (int k = 0; k < 5; k++)
         begin
            hold_ev(11'h004 << k, 1);
            rd_chk(efc_pkg::IDX_ALARM, 8'h01 << pos[k], efc_pkg::RESP_OKAY);
            rd_chk(efc_pkg::IDX_ALARM, 8'h00, efc_pkg::RESP_OKAY);
         end
         hold_ev(11'h07C, 2);
         wr_chk(efc_pkg::IDX_ALARM, 8'hFF, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_ALARM, 8'hE6, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_ALARM, 8'h00, efc_pkg::RESP_OKAY);
      end
   endtask

   task automatic t_line;
      begin
         send_bits(1, 1'b1, 1'b0);
         send_bits(191, 1'b0, 1'b0);
         rd_chk(efc_pkg::IDX_ALARM, 8'h00, efc_pkg::RESP_OKAY);
         send_bits(1, 1'b0, 1'b0);
         rd_chk(efc_pkg::IDX_ALARM, 8'h10, efc_pkg::RESP_OKAY);
         // two equal ones restart the alternation run from a clean reference
         send_bits(2, 1'b1, 1'b0);
         send_bits(511, 1'b0, 1'b1);
         rd_chk(efc_pkg::IDX_ALARM, 8'h00, efc_pkg::RESP_OKAY);
         send_bits(1, 1'b1, 1'b0);
         rd_chk(efc_pkg::IDX_ALARM, 8'h08, efc_pkg::RESP_OKAY);
      end
   endtask

   task automatic t_counts;
      begin
         hold_ev(11'h001, 5);
         hold_ev(11'h002, 3);
         hold_ev(11'h080, 7);
         hold_ev(11'h100, 300);
         hold_ev(11'h200, 261);
         hold_ev(11'h400, 515);
         rd_chk(efc_pkg::IDX_PRBS_ERR, 8'h05, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_PRBS_MF, 8'h03, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_FAS, 8'h07, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_EBIT_HI, 8'h01, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_EBIT_LO, 8'h2C, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_LV_HI, 8'h01, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_LV_LO, 8'h05, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_CRC_HI, 8'h02, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_CRC_LO, 8'h03, efc_pkg::RESP_OKAY);
         wr_chk(efc_pkg::IDX_EBIT_HI, 8'hFF, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_EBIT_HI, 8'h01, efc_pkg::RESP_OKAY);
         wr_chk(efc_pkg::IDX_PRBS_ERR, 8'hFE, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_PRBS_ERR, 8'hFE, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_PRBS_MF, 8'h00, efc_pkg::RESP_OKAY);
      end
   endtask

   task automatic t_wrap;
      begin
         wr_chk(efc_pkg::IDX_IRQ_MASK, 8'h01, efc_pkg::RESP_OKAY);
         hold_ev(11'h001, 2);
         rd_chk(efc_pkg::IDX_PRBS_ERR, 8'h00, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_IRQ_STAT, 8'h01, efc_pkg::RESP_OKAY);
         check("irq", {31'h0, irq}, 32'h1);
         wr_chk(efc_pkg::IDX_IRQ_STAT, 8'h01, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_IRQ_STAT, 8'h00, efc_pkg::RESP_OKAY);
         check("irq", {31'h0, irq}, 32'h0);
         hold_ev(11'h080, 249);
         rd_chk(efc_pkg::IDX_FAS, 8'h00, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_IRQ_STAT, 8'h04, efc_pkg::RESP_OKAY);
         check("irq", {31'h0, irq}, 32'h0);
         // 261 violations already counted, so this many more wrap the 16-bit count
         hold_ev(11'h200, 65275);
         rd_chk(efc_pkg::IDX_LV_HI, 8'h00, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_LV_LO, 8'h00, efc_pkg::RESP_OKAY);
         rd_chk(efc_pkg::IDX_IRQ_STAT, 8'h14, efc_pkg::RESP_OKAY);
      end
   endtask

   initial
   begin
      miscompares = 0;
      checked = 0;
      aresetn = 1'b0;
      s_axi_awaddr = 10'h000;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h00000000;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 10'h000;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      ev = 11'h000;
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_latch();
      t_line();
      t_counts();
      t_wrap();
      wrap_up();
   end
endmodule

`default_nettype wire
